// >>> rtl/hsc_cmd_pkg.sv
// shared constants, types and helpers for the serial command block
package hsc_cmd_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int ABANDON_MS = 35;
  localparam int ABANDON_CYC = ABANDON_MS * (CLK_HZ / 1000);
  localparam int IDLE_CNT_W = 20;
  // ****************************************
  // bus address and command codes
  // ****************************************
  localparam logic [6:0] BASE_ADDR_RST = 7'h10;
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_MFR_ID = 8'h99;
  localparam logic [7:0] CMD_PMON_CONTROL = 8'hd3;
  localparam logic [7:0] CMD_DEVICE_CONFIG = 8'hd4;
  localparam int ON_BIT = 7;
  localparam int UNLOCK_BIT = 0;
  localparam int CONVERT_BIT = 0;
  localparam logic ON_RST = 1'b1;
  localparam logic [1:0] LEN_BAD = 2'd3;
  // status byte fields
  localparam int ST_OFF_BIT = 6;
  localparam int ST_OV_BIT = 5;
  localparam int ST_UV_BIT = 3;
  localparam int ST_CML_BIT = 1;
  // arbitrary identification string, neutral value
  localparam logic [31:0] MFR_TEXT = 32'h48535743;
  localparam logic [3:0] MFR_LEN = 4'h4;
  // ****************************************
  // register map on the system bus
  // ****************************************
  localparam logic [7:0] ADDR_CFG_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] EXEC_CNT_OFF = 8'h08;
  localparam logic [3:0] BIT8 = 4'h8;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_RX, ST_ACK, ST_TX, ST_HACK} bus_state_t;
  typedef enum logic [1:0] {GS_LOCKOUT, GS_OFF, GS_ON} gate_state_t;
  // smbus packet error code, x^8+x^2+x+1, msb first
  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8
  // data bytes carried by each write command
  function automatic logic [1:0] cmdLen(input logic [7:0] cmd);
    case (cmd)
      CMD_OPERATION, CMD_DEVICE_CONFIG, CMD_PMON_CONTROL: cmdLen = 2'd1;
      CMD_CLEAR_FAULTS: cmdLen = 2'd0;
      default: cmdLen = LEN_BAD;
    endcase
  endfunction : cmdLen
endpackage : hsc_cmd_pkg

// >>> rtl/hsc_group_cmd.sv
// serial command target with group execution, block read and output enable
`timescale 1ns/1ns
`default_nettype none
module hsc_group_cmd
  import hsc_cmd_pkg::*;
#(
  parameter int unsigned ABANDON_CYCLES = ABANDON_CYC,
  parameter bit HAS_ENABLE = 1'b0
) (
  input wire logic clk, // system clock, 20 MHz
  input wire logic sys_rst, // synchronous reset, high
  input wire logic hsel, // ahb slave select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response
  input wire logic sclIn, // bus clock pin
  input wire logic sdaIn, // bus data pin level
  output logic sdaOut, // bus data drive value
  output logic sdaOe, // bus data drive enable
  input wire logic [1:0] addrSel, // address strap pins
  input wire logic undervoltageInput, // high when supply sufficient
  input wire logic overvoltageInput, // high on overvoltage
  input wire logic supplyLockout, // high while supply locked out
  input wire logic hotswapPermit, // timer, soft start and sense allow
  input wire logic enableInput, // enable pin of the variant
  input wire logic convertTriggerPin, // hardware convert trigger
  output logic gateOn, // fet gate drive enable
  output logic sampleStart // one-cycle sampling start
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [7:0] pinA_q;
  logic [7:0] pinB_q;
  logic uvS, ovS, lockS, permS, enS, convS;
  logic convPrev_q;
  logic [1:0] strap_q;
  always_ff @(posedge clk) begin
    pinA_q <= {addrSel, convertTriggerPin, enableInput, hotswapPermit,
               supplyLockout, overvoltageInput, undervoltageInput};
    pinB_q <= pinA_q;
  end
  assign {convS, enS, permS, lockS, ovS, uvS} = pinB_q[5:0];
  // strap sampled while reset is asserted, so reset must last three edges
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strap_q <= pinB_q[7:6];
      convPrev_q <= 1'b0;
    end else begin
      convPrev_q <= convS;
    end
  end
  // ****************************************
  // byte engine
  // ****************************************
  smbus_line_if L ();
  smbus_line_monitor u_mon (
    .clk(clk),
    .sys_rst(sys_rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .L(L.mon)
  );
  bus_state_t state_q;
  logic [3:0] bitCnt_q, txIdx_q;
  logic [7:0] shift_q, cmd_q, data_q, crc_q, txShift_q, txByte, statusByte;
  logic [2:0] wrCnt_q;
  logic rdMode_q, myWr_q, sdaOe_q, sdaOut_q, unlock_q, onBit_q;
  logic [6:0] baseAddr_q, myAddr;
  logic cmdLocked, addrHit;
  assign myAddr = {baseAddr_q[6:2], strap_q};
  assign addrHit = shift_q[7:1] == myAddr;
  assign cmdLocked = wrCnt_q == 3'd0 && shift_q == CMD_OPERATION && !unlock_q;
  always_comb begin
    logic [3:0] len;
    len = 4'h0;
    txByte = 8'hff;
    case (cmd_q)
      CMD_STATUS_BYTE: len = 4'h1;
      CMD_STATUS_WORD: len = 4'h2;
      CMD_MFR_ID: len = MFR_LEN + 4'h1;
      default: len = 4'h0;
    endcase
    if (txIdx_q < len) begin
      if (cmd_q == CMD_MFR_ID) begin
        txByte = (txIdx_q == 4'h0) ? {4'h0, MFR_LEN} : MFR_TEXT[8*(MFR_LEN-txIdx_q) +: 8];
      end else begin
        txByte = (txIdx_q == 4'h0) ? statusByte : 8'h00;
      end
    end else if (txIdx_q == len && len != 4'h0) begin
      txByte = crc_q;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      sdaOe_q <= 1'b0;
      sdaOut_q <= 1'b0;
      rdMode_q <= 1'b0;
      myWr_q <= 1'b0;
      wrCnt_q <= 3'd0;
      cmd_q <= 8'h00;
      data_q <= 8'h00;
      crc_q <= 8'h00;
      txShift_q <= 8'h00;
      txIdx_q <= 4'h0;
    end else if (L.startSeen) begin
      state_q <= ST_ADDR;
      bitCnt_q <= 4'h0;
      sdaOe_q <= 1'b0;
      myWr_q <= 1'b0;
      wrCnt_q <= 3'd0;
      // a command-only write followed by a read keeps its error code running
      if (!(myWr_q && wrCnt_q == 3'd1)) crc_q <= 8'h00;
    end else if (L.stopSeen) begin
      state_q <= ST_IDLE;
      sdaOe_q <= 1'b0;
      myWr_q <= 1'b0;
      wrCnt_q <= 3'd0;
    end else begin
      case (state_q)
        ST_ADDR, ST_RX: begin
          if (L.sclRise && bitCnt_q != BIT8) begin
            shift_q <= {shift_q[6:0], L.sdaLvl};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (L.sclFall && bitCnt_q == BIT8) begin
            bitCnt_q <= 4'h0;
            crc_q <= crc8(crc_q, shift_q);
            if (state_q == ST_RX) begin
              state_q <= ST_ACK;
              sdaOe_q <= !cmdLocked;
              if (wrCnt_q == 3'd0) cmd_q <= shift_q;
              if (wrCnt_q == 3'd1) data_q <= shift_q;
              if (wrCnt_q != 3'd7) wrCnt_q <= wrCnt_q + 3'd1;
            end else if (addrHit) begin
              state_q <= ST_ACK;
              sdaOe_q <= 1'b1;
              rdMode_q <= shift_q[0];
              myWr_q <= !shift_q[0];
              txIdx_q <= 4'h0;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (L.sclFall) begin
            bitCnt_q <= 4'h0;
            state_q <= rdMode_q ? ST_TX : ST_RX;
            txShift_q <= txByte;
            sdaOe_q <= rdMode_q && !txByte[7];
          end
        end
        ST_TX: begin
          if (L.sclFall && bitCnt_q[2:0] == 3'd7) begin
            sdaOe_q <= 1'b0;
            state_q <= ST_HACK;
            crc_q <= crc8(crc_q, txShift_q);
            if (txIdx_q != 4'hf) txIdx_q <= txIdx_q + 4'h1;
          end else if (L.sclFall) begin
            sdaOe_q <= !txShift_q[3'd6 - bitCnt_q[2:0]];
            bitCnt_q <= bitCnt_q + 4'h1;
          end
        end
        ST_HACK: begin
          // host nack ends the read; wait for its stop
          if (L.sclRise && L.sdaLvl) begin
            state_q <= ST_IDLE;
          end else if (L.sclFall) begin
            state_q <= ST_TX;
            bitCnt_q <= 4'h0;
            txShift_q <= txByte;
            sdaOe_q <= !txByte[7];
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  no_group_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_ADDR && L.sclFall && bitCnt_q == BIT8 && !addrHit && !L.startSeen
     && !L.stopSeen) |=> (state_q == ST_IDLE && !sdaOe_q))
    else $error("foreign address was answered");
  addr_ack_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_ADDR && L.sclFall && bitCnt_q == BIT8 && addrHit && !L.startSeen
     && !L.stopSeen) |=> (sdaOe_q && state_q == ST_ACK))
    else $error("own address not acknowledged");
  lock_nack_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_RX && L.sclFall && bitCnt_q == BIT8 && cmdLocked && !L.startSeen
     && !L.stopSeen) |=> !sdaOe_q)
    else $error("locked operation command acknowledged");
  block_count_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_ACK && rdMode_q && L.sclFall && cmd_q == CMD_MFR_ID && !L.startSeen
     && !L.stopSeen) |=> (txShift_q == {4'h0, MFR_LEN}))
    else $error("block read did not open with byte count");
  // ****************************************
  // message end, pending hold and execution
  // ****************************************
  logic [1:0] expLen;
  logic msgGood, msgBadPec, pend_q, execValid_q, cmlFlt_q;
  logic [7:0] pendCmd_q, pendData_q, execCmd_q, execData_q;
  logic [IDLE_CNT_W-1:0] idleCnt_q;
  logic abandon;
  assign expLen = cmdLen(cmd_q);
  assign msgGood = myWr_q && expLen != LEN_BAD && (wrCnt_q == {1'b0, expLen} + 3'd1
                   || (wrCnt_q == {1'b0, expLen} + 3'd2 && crc_q == 8'h00));
  assign msgBadPec = myWr_q && expLen != LEN_BAD && wrCnt_q == {1'b0, expLen} + 3'd2
                     && crc_q != 8'h00;
  assign abandon = idleCnt_q >= IDLE_CNT_W'(ABANDON_CYCLES - 1);
  always_ff @(posedge clk) begin
    if (sys_rst || L.sclRise || L.sclFall || L.startSeen || L.stopSeen) begin
      idleCnt_q <= '0;
    end else if (!abandon) begin
      idleCnt_q <= idleCnt_q + IDLE_CNT_W'(1);
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
      pendCmd_q <= 8'h00;
      pendData_q <= 8'h00;
      execValid_q <= 1'b0;
      execCmd_q <= 8'h00;
      execData_q <= 8'h00;
    end else begin
      execValid_q <= 1'b0;
      if (L.stopSeen) begin
        pend_q <= 1'b0;
        execValid_q <= msgGood || pend_q;
        execCmd_q <= msgGood ? cmd_q : pendCmd_q;
        execData_q <= msgGood ? data_q : pendData_q;
      end else if (L.startSeen && msgGood) begin
        pend_q <= 1'b1;
        pendCmd_q <= cmd_q;
        pendData_q <= data_q;
      end else if (abandon) begin
        pend_q <= 1'b0;
      end
    end
  end
  exec_at_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
    execValid_q |-> $past(L.stopSeen))
    else $error("command executed away from a stop");
  pend_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (L.startSeen && msgGood) |=> (pend_q && !execValid_q))
    else $error("group command not held pending");
  pec_discard_a: assert property (@(posedge clk) disable iff (sys_rst)
    (L.stopSeen && msgBadPec && !pend_q) |=> (!execValid_q && cmlFlt_q))
    else $error("bad error code command executed or unflagged");
  abandon_a: assert property (@(posedge clk) disable iff (sys_rst)
    (pend_q && abandon && !L.stopSeen && !L.startSeen) |=> (!pend_q && !execValid_q))
    else $error("abandoned command kept pending");
  // ****************************************
  // command effects and latched faults
  // ****************************************
  logic execOper, clrFaults, uvFlt_q, ovFlt_q, sampleStart_q;
  logic [15:0] execCnt_q;
  assign execOper = execValid_q && execCmd_q == CMD_OPERATION && unlock_q;
  assign clrFaults = (execOper && !onBit_q && execData_q[ON_BIT])
                     || (execValid_q && execCmd_q == CMD_CLEAR_FAULTS);
  assign statusByte = {1'b0, !gateOn, ovFlt_q, 1'b0, uvFlt_q, 1'b0, cmlFlt_q, 1'b0};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      onBit_q <= ON_RST;
      unlock_q <= 1'b0;
      sampleStart_q <= 1'b0;
      execCnt_q <= 16'h0000;
    end else begin
      if (execOper) onBit_q <= execData_q[ON_BIT];
      if (execValid_q && execCmd_q == CMD_DEVICE_CONFIG) unlock_q <= execData_q[UNLOCK_BIT];
      sampleStart_q <= (execValid_q && execCmd_q == CMD_PMON_CONTROL
                        && execData_q[CONVERT_BIT]) || (convS && !convPrev_q);
      if (execValid_q) execCnt_q <= execCnt_q + 16'h0001;
    end
  end
  // a fault condition still present sets again over the clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      uvFlt_q <= 1'b0;
      ovFlt_q <= 1'b0;
      cmlFlt_q <= 1'b0;
    end else begin
      uvFlt_q <= !uvS || (uvFlt_q && !clrFaults);
      ovFlt_q <= ovS || (ovFlt_q && !clrFaults);
      cmlFlt_q <= ((L.stopSeen || L.startSeen) && msgBadPec) || (cmlFlt_q && !clrFaults);
    end
  end
  reset_default_a: assert property (@(posedge clk)
    sys_rst |=> (onBit_q && !unlock_q))
    else $error("on bit or lock wrong after reset");
  convert_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    (execValid_q && execCmd_q == CMD_PMON_CONTROL && execData_q[CONVERT_BIT]) |=> sampleStart_q)
    else $error("convert command did not start sampling");
  fault_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    (execOper && !onBit_q && execData_q[ON_BIT] && uvS && !ovS) |=> (!uvFlt_q && !ovFlt_q))
    else $error("off then on did not clear faults");
  // ****************************************
  // gate state machine
  // ****************************************
  gate_state_t gs_q, gsD;
  logic permit, gateOn_q;
  // on bit, undervoltage and enable all gate the drive
  assign permit = onBit_q && uvS && !ovS && permS && (!HAS_ENABLE || enS);
  always_comb begin
    gsD = gs_q;
    case (gs_q)
      GS_LOCKOUT: gsD = lockS ? GS_LOCKOUT : GS_OFF;
      GS_OFF: gsD = lockS ? GS_LOCKOUT : (permit ? GS_ON : GS_OFF);
      GS_ON: gsD = lockS ? GS_LOCKOUT : (permit ? GS_ON : GS_OFF);
      default: gsD = GS_LOCKOUT;
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gs_q <= GS_LOCKOUT;
      gateOn_q <= 1'b0;
    end else begin
      gs_q <= gsD;
      gateOn_q <= gsD == GS_ON;
    end
  end
  uv_blocks_a: assert property (@(posedge clk) disable iff (sys_rst)
    !uvS |=> !gateOn_q)
    else $error("gate on with undervoltage");
  off_holds_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!onBit_q && permS && uvS && !ovS) |=> !gateOn_q)
    else $error("gate on while software disabled it");
  ov_blocks_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ovS && onBit_q) |=> !gateOn_q)
    else $error("gate on with overvoltage");
  // ****************************************
  // ahb-lite slave, zero wait states
  // ****************************************
  logic [31:0] hrdata_q;
  logic hreadyout_q, hresp_q, wrPend_q;
  logic [7:0] wrOff_q;
  logic acc;
  assign acc = hsel && htrans[1] && hready;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      wrPend_q <= 1'b0;
      wrOff_q <= 8'h00;
      baseAddr_q <= BASE_ADDR_RST;
    end else begin
      wrPend_q <= acc && hwrite;
      if (acc) wrOff_q <= haddr[7:0];
      if (wrPend_q && wrOff_q == ADDR_CFG_OFF) baseAddr_q <= hwdata[6:0];
      if (acc && !hwrite) begin
        case (haddr[7:0])
          ADDR_CFG_OFF: hrdata_q <= {25'h0, baseAddr_q};
          STATUS_OFF: hrdata_q <= {24'h0, pend_q, unlock_q, onBit_q, cmlFlt_q,
                                   ovFlt_q, uvFlt_q, 1'b0, gateOn_q};
          EXEC_CNT_OFF: hrdata_q <= {16'h0, execCnt_q};
          default: hrdata_q <= 32'h00000000;
        endcase
      end
    end
  end
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign sdaOut = sdaOut_q;
  assign sdaOe = sdaOe_q;
  assign gateOn = gateOn_q;
  assign sampleStart = sampleStart_q;
endmodule : hsc_group_cmd
`default_nettype wire

// >>> rtl/smbus_line_if.sv
// bus line events passed from the line monitor to the command engine
`timescale 1ns/1ns
`default_nettype none
interface smbus_line_if;
  logic sclRise;
  logic sclFall;
  logic sdaLvl;
  logic startSeen;
  logic stopSeen;
  modport mon (output sclRise, sclFall, sdaLvl, startSeen, stopSeen);
  modport eng (input sclRise, sclFall, sdaLvl, startSeen, stopSeen);
endinterface : smbus_line_if
`default_nettype wire

// >>> rtl/smbus_line_monitor.sv
// synchroniser and edge, start and stop detection for the serial bus lines
`timescale 1ns/1ns
`default_nettype none
module smbus_line_monitor (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic sclIn, // bus clock pin
  input wire logic sdaIn, // bus data pin
  smbus_line_if.mon L // events to the engine
);
  logic [1:0] sclSync_q;
  logic [1:0] sdaSync_q;
  logic sclPrev_q;
  logic sdaPrev_q;
  // idle lines are high, so reset to high to avoid a false start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      sclPrev_q <= sclSync_q[1];
      sdaPrev_q <= sdaSync_q[1];
    end
  end
  always_comb begin
    L.sclRise = sclSync_q[1] && !sclPrev_q;
    L.sclFall = !sclSync_q[1] && sclPrev_q;
    L.sdaLvl = sdaSync_q[1];
    L.startSeen = sclSync_q[1] && sclPrev_q && sdaPrev_q && !sdaSync_q[1];
    L.stopSeen = sclSync_q[1] && sclPrev_q && !sdaPrev_q && sdaSync_q[1];
  end
  start_stop_excl_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(L.startSeen && (L.stopSeen || L.sclFall || L.sclRise)))
    else $error("start seen together with another line event");
endmodule : smbus_line_monitor
`default_nettype wire

// >>> tb/hsc_group_cmd_tb.sv
// self-checking bench for group writes, block read and gate drive; enable variant off, enable pin tied low
`timescale 1ns/1ns
`default_nettype none
module hsc_group_cmd_tb import hsc_cmd_pkg::*; ;
  logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b1, hwrite = 1'b0, uv = 1'b1, ov = 1'b0;
  logic lock = 1'b1, convert_trigger_pin = 1'b0, hreadyout, hresp, sdaOut, sdaOe, scl, sda, gateOn, sampleStart;
  logic perm = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [2:0] ak;
  logic [7:0] q, rb [5];
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, st;
  int err_total = 0, compares = 0, pulses = 0;
  // crc-8 over address 0x20, command, data: config unlock and output off
  localparam logic [7:0] PEC_CFG = 8'haa, PEC_OFF = 8'h56;
  initial forever #25 clk = ~clk;
  hsc_group_cmd #(.ABANDON_CYCLES(200)) DUT (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sclIn(scl),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSel(2'h0), .undervoltageInput(uv),
    .overvoltageInput(ov), .supplyLockout(lock), .hotswapPermit(perm), .enableInput(1'b0),
    .convertTriggerPin(convert_trigger_pin), .gateOn(gateOn), .sampleStart(sampleStart));
  smbus_host_model host (.clk(clk), .sdaOe(sdaOe), .scl(scl), .sda(sda));
  always @(posedge clk) if (sampleStart === 1'b1) pulses++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) err_total++;
    if (seen !== exp) $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    {htrans, haddr, hwrite} <= {2'h2, 24'h0, a, w};
    do @(posedge clk); while (hreadyout !== 1'b1);
    {htrans, hwdata} <= {2'h0, wd};
    do @(posedge clk); while (hreadyout !== 1'b1);
    st = hrdata;
  endtask : ahb
  task automatic nx(input string s);
    repeat (20) @(posedge clk);
    $display("test %s done", s);
  endtask : nx
  task automatic w3(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d, input logic p);
    host.start();
    host.xb(a, 1'b1, q, ak[2]);
    host.xb(c, 1'b1, q, ak[1]);
    host.xb(d, 1'b1, q, ak[0]);
    if (p) host.stop();
  endtask : w3
  task automatic rd(input logic [7:0] c, input int n);
    host.start();
    host.xb(8'h20, 1'b1, q, ak[2]);
    host.xb(c, 1'b1, q, ak[1]);
    host.start();
    host.xb(8'h21, 1'b1, q, ak[0]);
    for (int i = 0; i < n; i++) host.xb(8'hff, i == n - 1, rb[i], ak[0]);
    host.stop();
  endtask : rd
  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    ahb(1'b0, STATUS_OFF, 32'h0);
    chk({hresp, st[7:5], st[0]}, 5'b00010);
    lock <= 1'b0;
    nx("lockout");
    chk(gateOn, 1'b1);
    perm <= 1'b0;
    nx("permit");
    chk(gateOn, 1'b0);
    perm <= 1'b1;
    uv <= 1'b0;
    nx("undervoltage");
    chk(gateOn, 1'b0);
    uv <= 1'b1;
    w3(8'h20, CMD_OPERATION, 8'h00, 1'b1);
    nx("locked");
    chk({ak[2:1], gateOn}, 3'b011);
    w3(8'h20, CMD_DEVICE_CONFIG, 8'h01, 1'b0);
    host.xb(~PEC_CFG, 1'b1, q, ak[0]);
    host.stop();
    nx("bad pec");
    ahb(1'b0, STATUS_OFF, 32'h0);
    chk({st[6], st[4]}, 2'b01);
    host.start();
    host.xb(8'h20, 1'b1, q, ak[2]);
    host.xb(CMD_CLEAR_FAULTS, 1'b1, q, ak[1]);
    host.stop();
    nx("clear faults");
    ahb(1'b0, STATUS_OFF, 32'h0);
    chk(st[4:2], 3'b000);
    w3(8'h20, CMD_DEVICE_CONFIG, 8'h01, 1'b1);
    chk(ak, 3'b000);
    w3(8'h20, CMD_OPERATION, 8'h00, 1'b0);
    host.xb(PEC_OFF, 1'b1, q, ak[0]);
    host.start();
    host.xb(8'h22, 1'b1, q, ak[2]);
    ahb(1'b0, STATUS_OFF, 32'h0);
    chk({ak[2], st[7], gateOn}, 3'b111);
    host.stop();
    nx("group off");
    chk(gateOn, 1'b0);
    rd(CMD_STATUS_BYTE, 1);
    chk(rb[0][ST_OFF_BIT], 1'b1);
    rd(CMD_STATUS_WORD, 2);
    chk({rb[1], rb[0][ST_OFF_BIT]}, 9'h001);
    ov <= 1'b1;
    w3(8'h20, CMD_OPERATION, 8'h80, 1'b1);
    nx("overvoltage");
    chk(gateOn, 1'b0);
    ov <= 1'b0;
    w3(8'h20, CMD_OPERATION, 8'h00, 1'b1);
    w3(8'h20, CMD_OPERATION, 8'h80, 1'b1);
    nx("clear");
    ahb(1'b0, STATUS_OFF, 32'h0);
    chk({st[3:2], st[0]}, 3'b001);
    w3(8'h20, CMD_PMON_CONTROL, 8'h01, 1'b0);
    host.start();
    host.xb(8'h22, 1'b1, q, ak[2]);
    chk(pulses, 0);
    host.stop();
    nx("group convert");
    chk(pulses, 1);
    convert_trigger_pin <= 1'b1;
    nx("convert pin");
    chk(pulses, 2);
    rd(CMD_MFR_ID, 5);
    chk(rb[0], MFR_LEN);
    chk({rb[1], rb[2], rb[3], rb[4]}, MFR_TEXT);
    w3(8'h20, CMD_OPERATION, 8'h00, 1'b0);
    host.start();
    repeat (400) @(posedge clk);
    ahb(1'b0, STATUS_OFF, 32'h0);
    chk(st[7], 1'b0);
    host.stop();
    nx("abandon");
    chk(gateOn, 1'b1);
    ahb(1'b1, ADDR_CFG_OFF, 32'h18);
    w3(8'h20, CMD_PMON_CONTROL, 8'h00, 1'b1);
    chk(ak[2], 1'b1);
    w3(8'h30, CMD_PMON_CONTROL, 8'h00, 1'b1);
    chk(ak, 3'b000);
    nx("address");
    wrap_up();
  end
endmodule : hsc_group_cmd_tb
`default_nettype wire

// >>> tb/smbus_host_model.sv
// bench host for the serial bus: clock stands high between frames
`timescale 1ns/1ns
`default_nettype none
module smbus_host_model (
  input wire logic clk, // system clock
  input wire logic sdaOe, // device pulls data low
  output logic scl = 1'b1, // bus clock, 8 clk a period
  output logic sda // data wire with pull-up
);
  logic drv = 1'b1;
  assign sda = drv & !sdaOe;
  // each step holds clock and data for 2 clk, data moves mid-low except in start and stop
  task automatic seq(input logic [9:0] p, input int n);
    for (int i = 0; i < n; i++) begin
      {scl, drv} <= p[9 - 2 * i -: 2];
      repeat (2) @(posedge clk);
    end
  endtask : seq
  // first step waits out the device's ack release; only writes go in a group
  task automatic start();
    seq(10'h178, 5);
  endtask : start
  task automatic stop();
    seq(10'h02c, 4);
  endtask : stop
  // ninth bit: released for the device ack, set high on the last read byte
  task automatic xb(input logic [7:0] d, input logic nack, output logic [7:0] q, output logic a);
    logic [8:0] v;
    logic [8:0] r;
    v = {d, nack};
    for (int i = 8; i >= 0; i--) begin
      seq({1'b0, v[i], 1'b1, v[i], 1'b1, v[i], 4'h0}, 3);
      r = {r[7:0], sda};
      seq({1'b0, v[i], 8'h00}, 1);
    end
    {q, a} = r;
  endtask : xb
endmodule : smbus_host_model
`default_nettype wire
